/* File: pkg/ctm_core_if.sv */
`timescale 1ns/1ps
interface ctm_core_if;
  import ctm_pkg::*;
  logic [2:0] clk_sel;
  logic tick;
  ctm_mode_e mode;
  logic [1:0] io_fn;
  logic oc;
  logic pol;
  logic on_rise;
  logic a_evt;
  logic pwm_act;
  logic pin_a;
  logic pin_b;
  modport core(output clk_sel, mode, io_fn, oc, pol, on_rise, a_evt, pwm_act,
               input tick, pin_a, pin_b);
  modport clkgen(input clk_sel, output tick);
  modport outstage(input mode, io_fn, oc, pol, on_rise, a_evt, pwm_act,
                   output pin_a, pin_b);
endinterface

/* File: pkg/ctm_pkg.sv */
package ctm_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CNT_W = 10;
  localparam logic [7:0] ADR_CTL0 = 8'h00;
  localparam logic [7:0] ADR_CTL1 = 8'h04;
  localparam logic [7:0] ADR_CNTL = 8'h08;
  localparam logic [7:0] ADR_CNTH = 8'h0C;
  localparam logic [7:0] ADR_CAL = 8'h10;
  localparam logic [7:0] ADR_CAH = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [9:0] CA_RST = 10'h000;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam int CTL0_PAU_B = 7;
  localparam int CTL0_CK_LSB = 4;
  localparam int CTL0_ON_B = 3;
  localparam int CTL0_RP_LSB = 0;
  localparam int CTL1_M_LSB = 6;
  localparam int CTL1_IO_LSB = 4;
  localparam int CTL1_OC_B = 3;
  localparam int CTL1_POL_B = 2;
  localparam int CTL1_DPX_B = 1;
  localparam int CTL1_CCLR_B = 0;
  localparam int STAT_A_B = 0;
  localparam int STAT_P_B = 1;
  localparam int P_LSB = 7;
  localparam int SYS_DIV = 4;
  localparam int HI_DIV_A = 16;
  localparam int HI_DIV_B = 64;
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_HI16 = 3'h2;
  localparam logic [2:0] CK_HI64 = 3'h3;
  localparam logic [2:0] CK_TBC = 3'h4;
  localparam logic [2:0] CK_NONE = 3'h5;
  localparam logic [2:0] CK_EXT_R = 3'h6;
  localparam logic [2:0] CK_EXT_F = 3'h7;
  localparam logic [1:0] IO_KEEP = 2'h0;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TGL = 2'h3;
  typedef enum logic [1:0] {
    CTM_CMP = 2'h0,
    CTM_UNDEF = 2'h1,
    CTM_PWM = 2'h2,
    CTM_TMR = 2'h3
  } ctm_mode_e;
endpackage

/* File: verif/tb_ctm_timer.sv */
`timescale 1ns/1ps
module tb_ctm_timer;
  import ctm_pkg::*;
  logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic external_clock_pin, high_clock_tick, time_base_tick;
  logic output_pin_a, output_pin_b, match_a_evt, match_p_evt;
  logic [3:0] div_q;
  int failures, checks_done;

  ctm_timer dut_u (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_clock_pin(external_clock_pin),
    .high_clock_tick(high_clock_tick), .time_base_tick(time_base_tick),
    .output_pin_a(output_pin_a), .output_pin_b(output_pin_b),
    .match_a_evt(match_a_evt), .match_p_evt(match_p_evt));

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // High clock strobe every 4 cycles, time base every 8: rates stay checkable
  always @(posedge core_clk) begin
    div_q <= div_q + 4'h1;
    high_clock_tick <= (div_q[1:0] == 2'h3);
    time_base_tick <= (div_q[2:0] == 3'h7);
  end

  task automatic stop_test;
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input logic [9:0] lo, input logic [9:0] hi,
                     input logic [9:0] got);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'h1) begin
      failures++;
      $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask

  // One classic cycle; waits for ack, never assumes its latency
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                    output logic [31:0] rd);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("[FAIL] ack expected 1 seen 0");
      stop_test;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] d;
    wb(1'h1, adr, dat, d);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    wb(1'h0, adr, 8'h00, d);
    chk(nm, exp, d);
  endtask

  // High byte first so the low byte comes from the same snapshot
  task automatic rd_cnt(output logic [9:0] v);
    logic [31:0] h, l;
    wb(1'h0, ADR_CNTH, 8'h00, h);
    wb(1'h0, ADR_CNTL, 8'h00, l);
    v = {h[1:0], l[7:0]};
  endtask

  task automatic wait_evt(input logic sel_p, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((sel_p ? match_p_evt : match_a_evt) !== 1'h1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      $display("[FAIL] match pulse expected 1 seen 0");
      stop_test;
    end
  endtask

  task automatic t_regs;
    for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0, "reset value");
    wr(ADR_CTL1, 8'h5A);
    rdc(ADR_CTL1, 32'h5A, "control 1");
    wr(ADR_CTL1, 8'h00);
    wr(ADR_CAL, 8'hC3);
    wr(ADR_CAH, 8'hFE);
    rdc(ADR_CAH, 32'h02, "compare high");
    rdc(ADR_CAL, 32'hC3, "compare low");
    wr(ADR_CAL, 8'h11);
    wr(ADR_CAH, 8'h01);
    rdc(ADR_CAH, 32'h01, "compare high");
    rdc(ADR_CAL, 32'h11, "compare low");
    wr(ADR_CAL, 8'h77);
    rdc(ADR_CAH, 32'h01, "compare high");
    rdc(ADR_CAL, 32'h11, "buffered low");
    wr(ADR_CNTL, 8'h77);
    rdc(ADR_CNTH, 32'h0, "counter high");
    rdc(ADR_CNTL, 32'h0, "counter low");
    rdc(8'h1C, 32'h0, "unmapped");
  endtask

  task automatic t_rates;
    logic [9:0] exp [6] = '{10'h080, 10'h200, 10'h008, 10'h002, 10'h040, 10'h000};
    logic [9:0] v, w;
    for (int c = 0; c < 6; c++) begin
      wr(ADR_CTL0, 8'h00);
      wr(ADR_CTL0, {1'h0, 3'(c), 4'h8});
      repeat (510) @(posedge core_clk);
      wr(ADR_CTL0, {1'h1, 3'(c), 4'h8});
      rd_cnt(v);
      rng("tick count", (exp[c] > 4) ? exp[c] - 10'h4 : 10'h0, exp[c] + 10'h4, v);
      repeat (40) @(posedge core_clk);
      rd_cnt(w);
      chk("paused count", {22'h0, v}, {22'h0, w});
    end
    wr(ADR_CTL0, 8'h18);
    repeat (20) @(posedge core_clk);
    wr(ADR_CTL0, 8'h98);
    rd_cnt(w);
    rng("resumed count", v + 10'h14, v + 10'h1C, w);
    wr(ADR_CTL0, 8'h10);
    repeat (30) @(posedge core_clk);
    rd_cnt(v);
    chk("off count", {22'h0, w}, {22'h0, v});
    wr(ADR_CTL0, 8'h18);
    rd_cnt(v);
    rng("count after on", 10'h0, 10'h10, v);
  endtask

  task automatic t_ext;
    logic [9:0] v;
    for (int c = 6; c < 8; c++) begin
      external_clock_pin <= 1'h0;
      wr(ADR_CTL0, 8'h00);
      wr(ADR_CTL0, {1'h0, 3'(c), 4'h8});
      repeat (11) begin
        repeat (8) @(posedge core_clk);
        external_clock_pin <= ~external_clock_pin;
      end
      repeat (10) @(posedge core_clk);
      rd_cnt(v);
      chk("edge count", (c == 6) ? 32'h6 : 32'h5, {22'h0, v});
    end
  endtask

  task automatic t_cmp;
    logic [7:0] c1 [6] = '{8'h39, 8'h29, 8'h19, 8'h09, 8'h21, 8'h2D};
    logic ini [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
    logic aft [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    int n;
    wr(ADR_CAL, 8'h64);
    wr(ADR_CAH, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(ADR_CTL0, 8'h00);
      wr(ADR_CTL1, c1[i]);
      wr(ADR_CTL0, 8'h18);
      repeat (2) @(posedge core_clk);
      chk("initial pin", {31'h0, ini[i]}, {31'h0, output_pin_a});
      wait_evt(1'h0, n);
      chk("pin after match", {31'h0, aft[i]}, {31'h0, output_pin_a});
      chk("pin pair", {31'h0, ~output_pin_a}, {31'h0, output_pin_b});
      wait_evt(1'h0, n);
      chk("A period", 32'd100, 32'(n));
    end
    wr(ADR_CTL0, 8'h00);
    wr(ADR_CTL1, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(ADR_CTL0, 8'h00);
      wr(ADR_CTL0, {7'h0C, ~1'(p)});
      wait_evt(1'h1, n);
      wait_evt(1'h1, n);
      chk("P period", p ? 32'd1024 : 32'd128, 32'(n));
    end
    rdc(ADR_STAT, 32'h3, "status flags");
    wr(ADR_CTL0, 8'h00);
    wr(ADR_STAT, 8'h03);
    rdc(ADR_STAT, 32'h0, "status cleared");
  endtask

  task automatic t_pwm;
    logic [7:0] c1 [4] = '{8'h98, 8'h88, 8'h9C, 8'h90};
    logic lvl [4] = '{1'h1, 1'h0, 1'h0, 1'h0};
    int hi;
    for (int d = 0; d < 2; d++) begin
      wr(ADR_CTL0, 8'h00);
      wr(ADR_CAL, d ? 8'hC8 : 8'h20);
      wr(ADR_CAH, 8'h00);
      wr(ADR_CTL1, d ? 8'hAA : 8'hA8);
      wr(ADR_CTL0, 8'h19);
      repeat (300) @(posedge core_clk);
      hi = 0;
      repeat (d ? 200 : 128) begin
        @(posedge core_clk);
        if (output_pin_a === 1'h1) hi++;
      end
      chk("active cycles", d ? 32'd128 : 32'd32, 32'(hi));
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADR_CTL0, 8'h00);
      wr(ADR_CTL1, c1[i]);
      wr(ADR_CTL0, 8'h19);
      repeat (5) @(posedge core_clk);
      chk("forced level", {31'h0, lvl[i]}, {31'h0, output_pin_a});
    end
  endtask

  initial begin
    rst = 1'h1;
    div_q = 4'h0;
    high_clock_tick = 1'h0;
    time_base_tick = 1'h0;
    external_clock_pin = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    t_regs();
    t_rates();
    t_ext();
    t_cmp();
    t_pwm();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    stop_test();
  end
endmodule

/* File: verilog/ctm_clk_sel.sv */
`timescale 1ns/1ps
module ctm_clk_sel (
  input logic core_clk,
  input logic rst,
  input logic external_clock_pin,
  input logic high_clock_tick,
  input logic time_base_tick,
  ctm_core_if.clkgen cif
);
  import ctm_pkg::*;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [1:0] sys_q;
  logic [5:0] hi_q;
  logic tick_q;
  logic ext_r, ext_f, hi_a, hi_b;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  assign ext_r = ext_s2_q & ~ext_s3_q;
  assign ext_f = ~ext_s2_q & ext_s3_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sys_q <= 2'h0;
      hi_q <= 6'h00;
    end else begin
      sys_q <= sys_q + 2'h1;
      if (high_clock_tick) begin
        hi_q <= hi_q + 6'h01;
      end
    end
  end
  assign hi_a = high_clock_tick && (hi_q[3:0] == 4'(HI_DIV_A - 1));
  assign hi_b = high_clock_tick && (hi_q == 6'(HI_DIV_B - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      case (cif.clk_sel)
        CK_SYS4: tick_q <= (sys_q == 2'(SYS_DIV - 1));
        CK_SYS: tick_q <= 1'b1;
        CK_HI16: tick_q <= hi_a;
        CK_HI64: tick_q <= hi_b;
        CK_TBC: tick_q <= time_base_tick;
        CK_EXT_R: tick_q <= ext_r;
        CK_EXT_F: tick_q <= ext_f;
        default: tick_q <= 1'b0;
      endcase
    end
  end
  assign cif.tick = tick_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  undef_clock_a: assert property (cif.clk_sel == CK_NONE |=> !tick_q)
    else $error("reserved clock code produced a tick");
  ext_edge_a: assert property (cif.clk_sel == CK_EXT_F && ext_f |=> tick_q)
    else $error("falling pin edge missed");
endmodule

/* File: verilog/ctm_out_stage.sv */
`timescale 1ns/1ps
module ctm_out_stage (
  input logic core_clk,
  input logic rst,
  ctm_core_if.outstage cif
);
  import ctm_pkg::*;
  logic lvl_q, lvl_d;
  logic pin_a_q, pin_b_q;

  always_comb begin
    lvl_d = lvl_q;
    if (cif.mode == CTM_CMP) begin
      if (cif.on_rise) begin
        lvl_d = cif.oc;
      end else if (cif.a_evt) begin
        case (cif.io_fn)
          IO_LOW: lvl_d = 1'b0;
          IO_HIGH: lvl_d = 1'b1;
          IO_TGL: lvl_d = ~lvl_q;
          default: lvl_d = lvl_q;
        endcase
      end
    end else if (cif.mode == CTM_PWM) begin
      case (cif.io_fn)
        IO_KEEP: lvl_d = ~cif.oc;
        IO_LOW: lvl_d = cif.oc;
        IO_HIGH: lvl_d = cif.pwm_act ? cif.oc : ~cif.oc;
        default: lvl_d = lvl_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lvl_q <= 1'b0;
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b1;
    end else begin
      lvl_q <= lvl_d;
      // Pins frozen in timer mode so the pin may be reused elsewhere
      if (cif.mode == CTM_CMP || cif.mode == CTM_PWM) begin
        pin_a_q <= lvl_d ^ cif.pol;
        pin_b_q <= ~(lvl_d ^ cif.pol);
      end
    end
  end
  assign cif.pin_a = pin_a_q;
  assign cif.pin_b = pin_b_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  init_level_a: assert property (cif.mode == CTM_CMP && cif.on_rise |=> lvl_q == $past(cif.oc))
    else $error("output not reset to initial level");
  pwm_force_a: assert property (cif.mode == CTM_PWM && cif.io_fn == IO_LOW
      |=> pin_a_q == ($past(cif.oc) ^ $past(cif.pol)))
    else $error("forced active level wrong");
endmodule

/* File: verilog/ctm_timer.sv */
`timescale 1ns/1ps
// Functional notes
// - Counter is 10 bits, read as a low byte and a two-bit high byte.
// - Compare-A is a 10-bit read/write value split into low and high bytes.
// - Upper six bits of both high bytes always read zero.
// - Pause freezes the counter; clearing pause resumes from the kept value.
// - Clock select picks sys/4, sys, high/16, high/64, time base or pin edge.
// - Reserved clock code gives no clock; counter stays still.
// - On rising clears the counter; on falling stops and keeps the value.
// - Compare mode: on rising returns output to the initial level.
// - Compare-P matches counter bits 9..7, periods 128 to 896.
// - Compare-P zero gives a 1024 period, cleared by overflow.
// - Mode: 00 compare output, 10 PWM, 11 timer, 01 undefined.
// - Compare A match: keep, drive low, drive high or toggle the pin.
// - Requesting the level already present shows no pin change.
// - PWM output field: force inactive, force active, or waveform.
// - Output level bit: initial level in compare, active level in PWM.
// - Invert bit flips the output pin, except in timer and undefined modes.
// - Period/duty bit swaps the roles of compare-P and compare-A.
// - Clear select: A match when set, P match or overflow when clear.
// - Compare-A low write buffered; high read latches low into buffer.
// - Counter clears on overflow or selected match and raises a flag, except on overflow with clear select set outside PWM.
module ctm_timer (
  input logic core_clk,
  input logic rst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [ctm_pkg::ADR_W-1:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [ctm_pkg::DAT_W-1:0] wb_dat_i,
  output logic [ctm_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input logic external_clock_pin,
  input logic high_clock_tick,
  input logic time_base_tick,
  output logic output_pin_a,
  output logic output_pin_b,
  output logic match_a_evt,
  output logic match_p_evt
);
  import ctm_pkg::*;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  logic [7:0] timer_control_0_q;
  logic [7:0] timer_control_1_q;
  logic [9:0] cnt_q, cnt_d;
  logic [9:0] compare_a_value_q;
  logic [7:0] ca_buf_q;
  logic [7:0] cnt_buf_q;
  logic [1:0] flag_q;
  logic on_prev_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic ma_q, mp_q;

  logic pause_ctl, module_on, output_level_ctl, output_invert;
  logic period_duty_select, clear_select;
  logic [2:0] compare_p_field;
  logic [1:0] output_function_field;
  ctm_mode_e mode_field;
  logic acc, wr, rd, on_rise, tick_en;
  logic [10:0] nxt;
  logic [9:0] p_end;
  logic [10:0] duty;
  logic p_hit, a_hit, clr, a_evt, p_evt;
  logic [1:0] flag_set, flag_clr;

  ctm_core_if cif();

  assign pause_ctl = timer_control_0_q[CTL0_PAU_B];
  assign module_on = timer_control_0_q[CTL0_ON_B];
  assign compare_p_field = timer_control_0_q[CTL0_RP_LSB +: 3];
  assign mode_field = ctm_mode_e'(timer_control_1_q[CTL1_M_LSB +: 2]);
  assign output_function_field = timer_control_1_q[CTL1_IO_LSB +: 2];
  assign output_level_ctl = timer_control_1_q[CTL1_OC_B];
  assign output_invert = timer_control_1_q[CTL1_POL_B];
  assign period_duty_select = timer_control_1_q[CTL1_DPX_B];
  assign clear_select = timer_control_1_q[CTL1_CCLR_B];

  // Bus decode; ack_q blocks a second take of the same request
  assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;

  assign on_rise = module_on & ~on_prev_q;
  assign tick_en = module_on & ~pause_ctl & cif.tick & ~on_rise;

  always_comb begin
    nxt = {1'b0, cnt_q} + 11'h001;
    p_end = {compare_p_field, 7'h00};
    // Compare-P zero only matches at the wrap past full scale
    p_hit = (compare_p_field != 3'h0) ? (nxt[9:0] == p_end) : nxt[10];
    a_hit = (compare_a_value_q != CA_RST) && (nxt[9:0] == compare_a_value_q);
    if (mode_field == CTM_PWM) begin
      clr = period_duty_select ? a_hit : p_hit;
      p_evt = p_hit;
    end else begin
      clr = clear_select ? a_hit : p_hit;
      p_evt = ~clear_select & p_hit;
    end
    a_evt = a_hit;
  end

  always_comb begin
    if (period_duty_select) begin
      duty = (compare_p_field == 3'h0) ? 11'h400 : {1'b0, p_end};
    end else begin
      duty = {1'b0, compare_a_value_q};
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = CNT_RST;
    end else if (tick_en) begin
      cnt_d = clr ? CNT_RST : nxt[9:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_RST;
      on_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      on_prev_q <= module_on;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_control_0_q <= CTL0_RST;
      timer_control_1_q <= CTL1_RST;
    end else begin
      if (wr && hit(wb_adr_i, ADR_CTL0)) begin
        timer_control_0_q <= wb_dat_i[7:0];
      end
      if (wr && hit(wb_adr_i, ADR_CTL1)) begin
        timer_control_1_q <= wb_dat_i[7:0];
      end
    end
  end

  // Low bytes pass through a buffer so a 10-bit value moves as one unit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      compare_a_value_q <= CA_RST;
      ca_buf_q <= BUF_RST;
      cnt_buf_q <= BUF_RST;
    end else begin
      if (wr && hit(wb_adr_i, ADR_CAL)) begin
        ca_buf_q <= wb_dat_i[7:0];
      end else if (rd && hit(wb_adr_i, ADR_CAH)) begin
        ca_buf_q <= compare_a_value_q[7:0];
      end
      if (wr && hit(wb_adr_i, ADR_CAH)) begin
        compare_a_value_q <= {wb_dat_i[1:0], ca_buf_q};
      end
      if (rd && hit(wb_adr_i, ADR_CNTH)) begin
        cnt_buf_q <= cnt_q[7:0];
      end
    end
  end

  assign flag_set = {tick_en & p_evt, tick_en & a_evt};
  assign flag_clr = (wr && hit(wb_adr_i, ADR_STAT)) ? wb_dat_i[1:0] : 2'h0;

  // Write one clears; a flag raised in the same cycle survives
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_q <= FLAG_RST;
      ma_q <= 1'b0;
      mp_q <= 1'b0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
      ma_q <= flag_set[STAT_A_B];
      mp_q <= flag_set[STAT_P_B];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc;
      if (rd) begin
        case (wb_adr_i)
          ADR_CTL0: rdat_q <= {24'h000000, timer_control_0_q};
          ADR_CTL1: rdat_q <= {24'h000000, timer_control_1_q};
          ADR_CNTL: rdat_q <= {24'h000000, cnt_buf_q};
          ADR_CNTH: rdat_q <= {30'h0000_0000, cnt_q[9:8]};
          ADR_CAL: rdat_q <= {24'h000000, ca_buf_q};
          ADR_CAH: rdat_q <= {30'h0000_0000, compare_a_value_q[9:8]};
          ADR_STAT: rdat_q <= {30'h0000_0000, flag_q};
          default: rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign cif.clk_sel = timer_control_0_q[CTL0_CK_LSB +: 3];
  assign cif.mode = mode_field;
  assign cif.io_fn = output_function_field;
  assign cif.oc = output_level_ctl;
  assign cif.pol = output_invert;
  assign cif.on_rise = on_rise;
  assign cif.a_evt = tick_en & a_evt;
  assign cif.pwm_act = {1'b0, cnt_q} < duty;

  ctm_clk_sel u_clk_sel (
    .core_clk(core_clk),
    .rst(rst),
    .external_clock_pin(external_clock_pin),
    .high_clock_tick(high_clock_tick),
    .time_base_tick(time_base_tick),
    .cif(cif.clkgen)
  );

  ctm_out_stage u_out_stage (
    .core_clk(core_clk),
    .rst(rst),
    .cif(cif.outstage)
  );

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign output_pin_a = cif.pin_a;
  assign output_pin_b = cif.pin_b;
  assign match_a_evt = ma_q;
  assign match_p_evt = mp_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  hi_byte_zero_a: assert property (rd && hit(wb_adr_i, ADR_CNTH)
      |=> wb_ack_o && wb_dat_o[31:2] == 30'h0000_0000)
    else $error("counter high byte upper bits not zero");
  on_clear_a: assert property (on_rise |=> cnt_q == CNT_RST)
    else $error("counter not cleared on switch on");
  off_hold_a: assert property (!module_on |=> $stable(cnt_q))
    else $error("counter moved while off");
  pause_hold_a: assert property (pause_ctl && !on_rise |=> $stable(cnt_q))
    else $error("counter moved while paused");
  p_period_a: assert property (tick_en && mode_field != CTM_PWM && !clear_select
      && compare_p_field != 3'h0 && cnt_q == {compare_p_field, 7'h7F}
      |=> cnt_q == CNT_RST && flag_q[STAT_P_B])
    else $error("compare-P period wrong");
  overflow_a: assert property (tick_en && cnt_q == 10'h3FF |=> cnt_q == CNT_RST)
    else $error("counter did not wrap at full scale");
  a_clear_a: assert property (tick_en && mode_field != CTM_PWM && clear_select
      && a_hit |=> cnt_q == CNT_RST && flag_q[STAT_A_B] && match_a_evt)
    else $error("compare-A clear or flag missing");
  ca_pair_a: assert property (wr && hit(wb_adr_i, ADR_CAH)
      |=> compare_a_value_q == {$past(wb_dat_i[1:0]), $past(ca_buf_q)})
    else $error("compare-A pair not assembled");
  // Flag set must survive a write-one clear in the same cycle
  flag_keep_a: assert property (flag_set[STAT_A_B] |=> flag_q[STAT_A_B])
    else $error("compare-A flag lost");
  no_p_flag_a: assert property (tick_en && mode_field != CTM_PWM && clear_select
      |=> !match_p_evt)
    else $error("compare-P flag raised with A clear");
  pwm_period_a: assert property (tick_en && mode_field == CTM_PWM && period_duty_select
      && a_hit |=> cnt_q == CNT_RST)
    else $error("PWM period from compare-A wrong");
  ca_hi_zero_a: assert property (rd && hit(wb_adr_i, ADR_CAH)
      |=> wb_dat_o[31:2] == 30'h0000_0000)
    else $error("compare-A high byte upper bits not zero");
  cnt_latch_a: assert property (rd && hit(wb_adr_i, ADR_CNTH)
      |=> cnt_buf_q == $past(cnt_q[7:0]))
    else $error("counter low byte not latched");
  count_step_a: assert property (tick_en && !clr |=> cnt_q == $past(cnt_q) + 10'h001)
    else $error("counter did not advance by one");
endmodule
